/* File: design/rpb_config_bank.sv */
// configuration register bank of the root port bridge, wishbone classic slave
// What this block does
// - Unmarked reserved bits are preserved, writes ignored
// - Re-enabling the link triggers full retraining
// - Prefetch upper base and limit fully writable
// - Prefetch base resets FFF1, limit 0001
// - Message interrupt header at 90h reads A005
// - Subsystem capability header reads 0000800D
// - Subsystem identifier keeps first write only
// - Express capability list reads 0010
// - Virtual channel header reads 14010002
// - Port virtual channel capabilities read zero
// - Link declaration header reads 00010005
// - First link entry mixes read-only, write-once
// - Legacy control mixed, resets to zero
//
// Our own choice: the Wishbone register port.
module rpb_config_bank #(
  parameter logic [31:0] VENDOR_VAL = 32'h0000_1234, // value arbitrary
  parameter logic [31:0] DEVICE_VAL = 32'h0000_5678, // value arbitrary
  parameter logic [31:0] REVISION_VAL = 32'h0000_0001, // value arbitrary
  parameter logic [31:0] SUBSYS_VAL = 32'h0000_ABCD // value arbitrary
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [10:0] ADR_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        WE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic             ACK_O,
  input  wire logic        LINK_UP,
  input  wire logic [15:0] STATUS_SET,
  output logic             LINK_DISABLE,
  output logic             LINK_RETRAIN
);

  localparam int N = rpb_pkg::NUM_REGS;

  logic                     rst_meta_q;
  logic                     rst_n;
  logic                     up_s1_q;
  logic                     up_s2_q;
  logic                     up_s3_q;
  logic                     link_up_q;
  logic                     ack_q;
  logic [31:0]              dat_q;
  logic [rpb_pkg::OFS_W-1:0] word_idx;
  logic [31:0]              be;
  logic                     req;
  logic                     wr;
  logic [N-1:0]             hit;
  logic [31:0]              reg_q [N];
  logic [31:0]              rd_word;
  logic                     dis_prev_q;
  logic                     retrain_q;
  logic                     training_q;
  logic                     subsys_written_q;

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // link state pin: three flops, change taken when last two agree
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      up_s1_q <= 1'b0;
      up_s2_q <= 1'b0;
      up_s3_q <= 1'b0;
    end else begin
      up_s1_q <= LINK_UP;
      up_s2_q <= up_s1_q;
      up_s3_q <= up_s2_q;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      link_up_q <= 1'b0;
    end else if (up_s2_q == up_s3_q) begin
      link_up_q <= up_s3_q;
    end
  end

  // bus decode
  assign word_idx = ADR_I[10:2];
  assign be       = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign req      = CYC_I && STB_I;
  assign wr       = req && WE_I && ack_q;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  assign ACK_O = ack_q;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_reg
      localparam rpb_pkg::rpb_reg_type ENT = rpb_pkg::REG_TABLE[gi];
      localparam logic [31:0] RST =
        (gi == rpb_pkg::IDX_VENDOR)   ? VENDOR_VAL :
        (gi == rpb_pkg::IDX_DEVICE)   ? DEVICE_VAL :
        (gi == rpb_pkg::IDX_REVISION) ? REVISION_VAL :
        (gi == rpb_pkg::IDX_SUBSYS)   ? SUBSYS_VAL : ENT.rst;
      logic [31:0] set_bits;
      logic [31:0] lock_bits;

      assign hit[gi]   = (word_idx == ENT.ofs);
      assign set_bits  = (gi == rpb_pkg::IDX_STATUS) ? {16'h0000, STATUS_SET} : 32'h0000_0000;
      // control bits frozen while the link is up, except link disable
      assign lock_bits = link_up_q ? ENT.lk : 32'h0000_0000;

      rpb_reg_cell #(
        .RST_VAL  (RST),
        .WR_MASK  (ENT.wm),
        .W1C_MASK (ENT.w1c),
        .WO_MASK  (ENT.wo)
      ) u_cell (
        .clk    (CLK),
        .rst_n  (rst_n),
        .wr     (wr && hit[gi]),
        .wdata  (DAT_I),
        .be     (be),
        .lock   (lock_bits),
        .hw_set (set_bits),
        .q      (reg_q[gi])
      );
    end
  endgenerate

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        rd_word = rd_word | reg_q[i];
      end
    end
    if (hit[rpb_pkg::IDX_LINK_STS]) begin
      rd_word[rpb_pkg::LINK_STATUS_TRAIN_BIT]  = training_q;
      rd_word[rpb_pkg::LINK_STATUS_ACTIVE_BIT] = link_up_q;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      dat_q <= WE_I ? 32'h0000_0000 : rd_word;
    end
  end

  assign DAT_O = dat_q;

  // link disable and retrain on re-enable
  assign LINK_DISABLE = reg_q[rpb_pkg::IDX_LINK_CTRL][rpb_pkg::LINK_CONTROL_DISABLE_BIT];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dis_prev_q <= 1'b0;
      retrain_q  <= 1'b0;
    end else begin
      dis_prev_q <= LINK_DISABLE;
      retrain_q  <= dis_prev_q && !LINK_DISABLE;
    end
  end

  assign LINK_RETRAIN = retrain_q;

  // training shown until the link comes up again
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      training_q <= 1'b0;
    end else if (retrain_q) begin
      training_q <= 1'b1;
    end else if (link_up_q) begin
      training_q <= 1'b0;
    end
  end

  // assertion helper: subsystem identifier seen written
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      subsys_written_q <= 1'b0;
    end else if (wr && hit[rpb_pkg::IDX_SUBSYS]) begin
      subsys_written_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_ack_single: assert property (req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle after request");

  a_unmapped_zero: assert property (ack_q && !WE_I && $past(hit) == '0 |-> DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_msi_header: assert property (ack_q && !WE_I && $past(hit[rpb_pkg::IDX_MSI_HDR]) |-> DAT_O == 32'h0000_A005)
    else $error("message interrupt header wrong");

  a_subsys_header: assert property (reg_q[rpb_pkg::IDX_SUBSYS_HD] == 32'h0000_800D)
    else $error("subsystem capability header wrong");

  a_subsys_once: assert property (subsys_written_q |=> $stable(reg_q[rpb_pkg::IDX_SUBSYS]))
    else $error("subsystem identifier changed after first write");

  a_ro_headers: assert property (reg_q[rpb_pkg::IDX_EXP_LIST] == 32'h0000_0010
    && reg_q[rpb_pkg::IDX_VCH_HDR] == 32'h1401_0002
    && reg_q[rpb_pkg::IDX_VCH_ONE] == 32'h0000_0000
    && reg_q[rpb_pkg::IDX_LDECL_HDR] == 32'h0001_0005)
    else $error("read-only capability header wrong");

  a_vch_header: assert property (ack_q && !WE_I && $past(hit[rpb_pkg::IDX_VCH_HDR]) |-> DAT_O == 32'h1401_0002)
    else $error("virtual channel header read wrong");

  a_pf_upper_wr: assert property (wr && hit[rpb_pkg::IDX_PF_BASE_U] && SEL_I == 4'hF
    |=> reg_q[rpb_pkg::IDX_PF_BASE_U] == $past(DAT_I))
    else $error("prefetch upper base not written");

  a_pf_reset: assert property ($rose(rst_n) |-> reg_q[rpb_pkg::IDX_PF_BASE] == 32'h0000_FFF1
    && reg_q[rpb_pkg::IDX_PF_LIMIT] == 32'h0000_0001 && reg_q[rpb_pkg::IDX_LEGACY] == 32'h0000_0000)
    else $error("prefetch window reset value wrong");

  a_link_entry_ro: assert property (reg_q[rpb_pkg::IDX_LINK_ENT][15:1] == 15'h0000)
    else $error("link entry read-only bits changed");

  a_cap_start_ro: assert property (wr && hit[rpb_pkg::IDX_CAP_START] |=> $stable(reg_q[rpb_pkg::IDX_CAP_START]))
    else $error("read-only register changed on write");

  a_lock_hold: assert property (link_up_q && wr && hit[rpb_pkg::IDX_DEV_CTRL]
    |=> $stable(reg_q[rpb_pkg::IDX_DEV_CTRL]))
    else $error("control written while link up");

  a_w1c_clear: assert property (wr && hit[rpb_pkg::IDX_STATUS] && SEL_I[1] && DAT_I[15] && !STATUS_SET[15]
    |=> !reg_q[rpb_pkg::IDX_STATUS][15])
    else $error("status bit not cleared by write of one");

  a_set_wins: assert property (STATUS_SET[15] |=> reg_q[rpb_pkg::IDX_STATUS][15])
    else $error("status event lost");

  a_retrain_pulse: assert property ($fell(LINK_DISABLE) |=> LINK_RETRAIN ##1 !LINK_RETRAIN)
    else $error("retrain pulse missing on link re-enable");

  a_legacy_reset: assert property ($rose(rst_n) |-> reg_q[rpb_pkg::IDX_LEGACY] == 32'h0000_0000)
    else $error("legacy control reset wrong");

  // bus handshake and read data
  a_ack_no_req: assert property (!req && !ack_q |=> !ack_q)
    else $error("ack without request");

  a_dat_hold: assert property (!(req && !ack_q) |=> $stable(DAT_O))
    else $error("read data changed without request");

  a_dat_write_zero: assert property (ack_q && $past(WE_I) |-> DAT_O == 32'h0000_0000)
    else $error("write returned nonzero data");

  a_single_hit: assert property ($onehot0(hit))
    else $error("more than one register decoded");

  a_rst_outputs: assert property ($rose(rst_n) |-> !ACK_O && DAT_O == 32'h0000_0000
    && !LINK_DISABLE && !LINK_RETRAIN)
    else $error("outputs not idle after reset");

  // read-only headers, capabilities and pointers as seen on the bus
  a_subsys_hdr_rd: assert property (ack_q && !WE_I && $past(hit[rpb_pkg::IDX_SUBSYS_HD])
    |-> DAT_O == 32'h0000_800D)
    else $error("subsystem capability header read wrong");

  a_exp_list_rd: assert property (ack_q && !WE_I && $past(hit[rpb_pkg::IDX_EXP_LIST])
    |-> DAT_O == 32'h0000_0010)
    else $error("express capability list read wrong");

  a_vch_caps_rd: assert property (ack_q && !WE_I
    && ($past(hit[rpb_pkg::IDX_VCH_ONE]) || $past(hit[rpb_pkg::IDX_VCH_ONE + 1]))
    |-> DAT_O == 32'h0000_0000)
    else $error("port virtual channel capabilities not zero");

  a_ldecl_rd: assert property (ack_q && !WE_I && $past(hit[rpb_pkg::IDX_LDECL_HDR])
    |-> DAT_O == 32'h0001_0005)
    else $error("link declaration header read wrong");

  a_cap_start_rd: assert property (ack_q && !WE_I && $past(hit[rpb_pkg::IDX_CAP_START])
    |-> DAT_O == 32'h0000_0088)
    else $error("capability list start read wrong");

  // writable, write-once and write-one-to-clear fields
  a_pf_base_ro: assert property (wr && hit[rpb_pkg::IDX_PF_BASE]
    |=> reg_q[rpb_pkg::IDX_PF_BASE][3:0] == 4'h1)
    else $error("prefetch base read-only bits changed");

  a_pf_lim_upper: assert property (wr && hit[rpb_pkg::IDX_PF_LIM_U] && SEL_I == 4'hF
    |=> reg_q[rpb_pkg::IDX_PF_LIM_U] == $past(DAT_I))
    else $error("prefetch upper limit not written");

  a_subsys_first: assert property (wr && hit[rpb_pkg::IDX_SUBSYS] && !subsys_written_q && SEL_I == 4'hF
    |=> reg_q[rpb_pkg::IDX_SUBSYS] == $past(DAT_I))
    else $error("first subsystem identifier write lost");

  a_w1c_zero_keep: assert property (wr && hit[rpb_pkg::IDX_STATUS] && SEL_I[1] && !DAT_I[15]
    && reg_q[rpb_pkg::IDX_STATUS][15] |=> reg_q[rpb_pkg::IDX_STATUS][15])
    else $error("status bit cleared by write of zero");

  a_legacy_lock: assert property (link_up_q && wr && hit[rpb_pkg::IDX_LEGACY]
    |=> $stable(reg_q[rpb_pkg::IDX_LEGACY]))
    else $error("legacy control written while link up");

  a_legacy_write: assert property (!link_up_q && wr && hit[rpb_pkg::IDX_LEGACY] && SEL_I[0]
    |=> reg_q[rpb_pkg::IDX_LEGACY][2:0] == $past(DAT_I[2:0]))
    else $error("legacy control not written while link down");

  // link disable, retrain and synchronised link state
  a_disable_free: assert property (wr && hit[rpb_pkg::IDX_LINK_CTRL] && SEL_I[0]
    |=> LINK_DISABLE == $past(DAT_I[rpb_pkg::LINK_CONTROL_DISABLE_BIT]))
    else $error("link disable bit not written");

  a_retrain_cause: assert property (LINK_RETRAIN |-> $past(LINK_DISABLE, 2) && !$past(LINK_DISABLE))
    else $error("retrain pulse without link re-enable");

  a_train_set: assert property (retrain_q |=> training_q)
    else $error("training not shown after retrain");

  a_train_clear: assert property (link_up_q && !retrain_q |=> !training_q)
    else $error("training shown with link up");

  a_sync_filter: assert property (up_s2_q != up_s3_q |=> $stable(link_up_q))
    else $error("link state changed on disagreeing samples");

  c_write_upper: cover property (wr && hit[rpb_pkg::IDX_PF_LIM_U]);
  c_subsys_twice: cover property (subsys_written_q && wr && hit[rpb_pkg::IDX_SUBSYS]);
  c_retrain: cover property (LINK_RETRAIN);
  c_unmapped_rd: cover property (ack_q && !WE_I && $past(hit) == '0);
  c_legacy_locked: cover property (link_up_q && wr && hit[rpb_pkg::IDX_LEGACY]);

endmodule

/* File: inc/rpb_pkg.sv */
// register map and constants for the root port bridge configuration bank
package rpb_pkg;

  localparam int NUM_REGS = 51;
  localparam int OFS_W    = 9;

  // one entry per register: index offset, reset, writable, w1c, write-once, link-lock masks
  typedef struct packed {
    logic [8:0]  ofs;
    logic [31:0] rst;
    logic [31:0] wm;
    logic [31:0] w1c;
    logic [31:0] wo;
    logic [31:0] lk;
  } rpb_reg_type;

  localparam int IDX_VENDOR    = 0;
  localparam int IDX_DEVICE    = 1;
  localparam int IDX_STATUS    = 3;
  localparam int IDX_REVISION  = 4;
  localparam int IDX_CAP_START = 20;
  localparam int IDX_PF_BASE   = 16;
  localparam int IDX_PF_LIMIT  = 17;
  localparam int IDX_PF_BASE_U = 18;
  localparam int IDX_PF_LIM_U  = 19;
  localparam int IDX_SUBSYS_HD = 26;
  localparam int IDX_SUBSYS    = 27;
  localparam int IDX_MSI_HDR   = 28;
  localparam int IDX_EXP_LIST  = 32;
  localparam int IDX_DEV_CTRL  = 35;
  localparam int IDX_LINK_CTRL = 38;
  localparam int IDX_LINK_STS  = 39;
  localparam int IDX_LEGACY    = 45;
  localparam int IDX_VCH_HDR   = 46;
  localparam int IDX_VCH_ONE   = 47;
  localparam int IDX_LDECL_HDR = 49;
  localparam int IDX_LINK_ENT  = 50;

  localparam int LINK_CONTROL_DISABLE_BIT = 4;
  localparam int LINK_STATUS_TRAIN_BIT   = 11;
  localparam int LINK_STATUS_ACTIVE_BIT  = 13;

  localparam logic [31:0] Z = 32'h0000_0000;

  localparam rpb_reg_type REG_TABLE [NUM_REGS] = '{
    '{9'h000, Z,            Z,            Z,            Z,            Z},
    '{9'h002, Z,            Z,            Z,            Z,            Z},
    '{9'h004, Z,            32'h0000_0547, Z,           Z,            32'h0000_0547},
    '{9'h006, 32'h0000_0010, Z,           32'h0000_F900, Z,           Z},
    '{9'h008, Z,            Z,            Z,            Z,            Z},
    '{9'h009, 32'h0006_0400, Z,           Z,            Z,            Z},
    '{9'h00C, Z,            32'h0000_00FF, Z,           Z,            Z},
    '{9'h00E, 32'h0000_0001, Z,           Z,            Z,            Z},
    '{9'h018, Z,            Z,            Z,            Z,            Z},
    '{9'h019, Z,            32'h0000_00FF, Z,           Z,            Z},
    '{9'h01A, Z,            32'h0000_00FF, Z,           Z,            Z},
    '{9'h01C, 32'h0000_00F0, 32'h0000_00F0, Z,          Z,            Z},
    '{9'h01D, Z,            32'h0000_00F0, Z,           Z,            Z},
    '{9'h01E, Z,            Z,            32'h0000_F900, Z,           Z},
    '{9'h020, 32'h0000_FFF0, 32'h0000_FFF0, Z,          Z,            Z},
    '{9'h022, Z,            32'h0000_FFF0, Z,           Z,            Z},
    '{9'h024, 32'h0000_FFF1, 32'h0000_FFF0, Z,          Z,            Z},
    '{9'h026, 32'h0000_0001, 32'h0000_FFF0, Z,          Z,            Z},
    '{9'h028, Z,            32'hFFFF_FFFF, Z,           Z,            Z},
    '{9'h02C, Z,            32'hFFFF_FFFF, Z,           Z,            Z},
    '{9'h034, 32'h0000_0088, Z,           Z,            Z,            Z},
    '{9'h03C, Z,            32'h0000_00FF, Z,           Z,            Z},
    '{9'h03D, 32'h0000_0001, Z,           Z,            Z,            Z},
    '{9'h03E, Z,            32'h0000_0053, Z,           Z,            32'h0000_0053},
    '{9'h080, 32'hC803_9001, Z,           Z,            Z,            Z},
    '{9'h084, 32'h0000_0008, 32'h0000_0003, Z,          Z,            Z},
    '{9'h088, 32'h0000_800D, Z,           Z,            Z,            Z},
    '{9'h08C, Z,            Z,            Z,            32'hFFFF_FFFF, Z},
    '{9'h090, 32'h0000_A005, Z,           Z,            Z,            Z},
    '{9'h092, Z,            32'h0000_0001, Z,           Z,            Z},
    '{9'h094, Z,            32'hFFFF_FFFC, Z,           Z,            Z},
    '{9'h098, Z,            32'h0000_FFFF, Z,           Z,            Z},
    '{9'h0A0, 32'h0000_0010, Z,           Z,            Z,            Z},
    '{9'h0A2, 32'h0000_0142, Z,           Z,            32'h0000_0100, Z},
    '{9'h0A4, 32'h0000_8000, Z,           Z,            Z,            Z},
    '{9'h0A8, Z,            32'h0000_000F, Z,           Z,            32'h0000_000F},
    '{9'h0AA, Z,            Z,            32'h0000_000F, Z,           Z},
    '{9'h0AC, 32'h0321_4D02, Z,           Z,            32'h0000_0C00, Z},
    '{9'h0B0, Z,            32'h0000_00DB, Z,           Z,            32'h0000_00CB},
    '{9'h0B2, 32'h0000_1000, Z,           32'h0000_C000, Z,           Z},
    '{9'h0B4, 32'h0004_0000, Z,           Z,            32'hFFF8_0000, Z},
    '{9'h0B8, Z,            32'h0000_07FF, Z,           Z,            32'h0000_07FF},
    '{9'h0BA, Z,            Z,            32'h0000_01FF, Z,           Z},
    '{9'h0BC, Z,            32'h0000_000F, Z,           Z,            32'h0000_000F},
    '{9'h0C0, Z,            Z,            32'h0001_0000, Z,           Z},
    '{9'h0EC, Z,            32'h0000_0007, Z,           Z,            32'h0000_0007},
    '{9'h100, 32'h1401_0002, Z,           Z,            Z,            Z},
    '{9'h104, Z,            Z,            Z,            Z,            Z},
    '{9'h108, Z,            Z,            Z,            Z,            Z},
    '{9'h140, 32'h0001_0005, Z,           Z,            Z,            Z},
    '{9'h150, Z,            Z,            Z,            32'h00FF_0001, Z}
  };

endpackage

/* File: design/rpb_reg_cell.sv */
// one configuration register with rw, w1c, write-once and read-only bits
module rpb_reg_cell #(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] WR_MASK = 32'h0000_0000,
  parameter logic [31:0] W1C_MASK = 32'h0000_0000,
  parameter logic [31:0] WO_MASK = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] be,
  input  wire logic [31:0] lock,
  input  wire logic [31:0] hw_set,
  output logic      [31:0] q
);

  logic [31:0] rw_q;
  logic [31:0] w1c_q;
  logic [31:0] wo_q;
  logic        wo_done_q;

  localparam logic [31:0] RO_MASK = ~(WR_MASK | W1C_MASK | WO_MASK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rw_q <= RST_VAL & WR_MASK;
    end else if (wr) begin
      rw_q <= (rw_q & ~(WR_MASK & be & ~lock)) | (wdata & WR_MASK & be & ~lock);
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w1c_q <= RST_VAL & W1C_MASK;
    end else begin
      w1c_q <= ((w1c_q & ~({32{wr}} & wdata & be)) | hw_set) & W1C_MASK;
    end
  end

  // write-once bits all lock after the register's first write; rw and w1c bits stay writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wo_q      <= RST_VAL & WO_MASK;
      wo_done_q <= 1'b0;
    end else if (wr && !wo_done_q) begin
      wo_q      <= (wo_q & ~(WO_MASK & be)) | (wdata & WO_MASK & be);
      wo_done_q <= 1'b1;
    end
  end

  // reserved and read-only bits ignore writes
  assign q = rw_q | w1c_q | wo_q | (RST_VAL & RO_MASK);

endmodule

/* File: dv/rpb_config_bank_tb.sv */
// self-checking bench for the root port bridge configuration bank
module rpb_config_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        CLK;
  logic        RST_B;
  logic [10:0] ADR_I;
  logic [31:0] DAT_I;
  logic [31:0] DAT_O;
  logic [3:0]  SEL_I;
  logic        WE_I;
  logic        CYC_I;
  logic        STB_I;
  logic        ACK_O;
  logic        LINK_UP;
  logic [15:0] STATUS_SET;
  logic        LINK_DISABLE;
  logic        LINK_RETRAIN;
  int          n_errors;
  int          check_count;
  int          seed;
  int          retrain_cnt;
  time         ack_time;
  time         retrain_time;

  rpb_config_bank rpb_config_bank_i (
    .CLK          (CLK),
    .RST_B        (RST_B),
    .ADR_I        (ADR_I),
    .DAT_I        (DAT_I),
    .DAT_O        (DAT_O),
    .SEL_I        (SEL_I),
    .WE_I         (WE_I),
    .CYC_I        (CYC_I),
    .STB_I        (STB_I),
    .ACK_O        (ACK_O),
    .LINK_UP      (LINK_UP),
    .STATUS_SET   (STATUS_SET),
    .LINK_DISABLE (LINK_DISABLE),
    .LINK_RETRAIN (LINK_RETRAIN)
  );

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // retrain pulse seen at the sampling edge
  always @(posedge CLK) begin
    if (LINK_RETRAIN === 1'b1) begin
      retrain_cnt++;
      retrain_time = $time;
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // one classic wishbone cycle, released only after ack is sampled
  task automatic wb(input logic we, input logic [10:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= s;
    do begin
      @(posedge CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("ERROR %0t no ack at %h", $time, a);
      wrap_up();
    end
    r = DAT_O;
    ack_time = $time;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I  <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    wb(1'b1, a, d, s, r);
  endtask

  task automatic rd(input logic [10:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, 4'hF, r);
    chk(r, exp, $sformatf("read %h", a));
  endtask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) old[8*i +: 8] = d[8*i +: 8];
    end
    return old;
  endfunction

  logic [10:0] ra [12] = '{11'h090, 11'h098, 11'h0A0, 11'h0B0, 11'h240, 11'h220,
                           11'h280, 11'h400, 11'h410, 11'h500, 11'h540, 11'h3B0};
  logic [31:0] rv [12] = '{32'h0000_FFF1, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
                           32'h0000_A005, 32'h0000_800D, 32'h0000_0010, 32'h1401_0002,
                           32'h0000_0000, 32'h0001_0005, 32'h0000_0000, 32'h0000_0000};

  initial begin
    logic [31:0] d;
    logic [31:0] m;
    logic [3:0]  s;
    n_errors = 0;
    check_count = 0;
    retrain_cnt = 0;
    seed = 32'h4f03_6085;
    RST_B = 1'b0;
    ADR_I = 11'h000;
    DAT_I = 32'h0000_0000;
    SEL_I = 4'h0;
    WE_I = 1'b0;
    CYC_I = 1'b0;
    STB_I = 1'b0;
    LINK_UP = 1'b0;
    STATUS_SET = 16'h0000;
    tick(8);
    RST_B <= 1'b1;
    tick(3);
    for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
    rd(11'h420, 32'h0000_0000);
    $display("test reset values done");
    m = 32'h0000_0000;
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      s = (i == 0) ? 4'hF : 4'($random(seed));
      m = merge(m, d, s);
      wr(11'h0A0, d, s);
      rd(11'h0A0, m);
      wr(11'h0B0, ~d, 4'hF);
      rd(11'h0B0, ~d);
    end
    d = $random(seed);
    wr(11'h090, d, 4'hF);
    rd(11'h090, (d & 32'h0000_FFF0) | 32'h0000_0001);
    $display("test prefetch window done");
    for (int i = 4; i < 10; i++) begin
      wr(ra[i], $random(seed), 4'hF);
      rd(ra[i], rv[i]);
    end
    wr(11'h0D0, 32'hFFFF_FFFF, 4'hF);
    rd(11'h0D0, 32'h0000_0088);
    wr(11'h140, 32'hFFFF_FFFF, 4'hF);
    rd(11'h140, 32'h0000_0000);
    wr(11'h7FC, 32'hFFFF_FFFF, 4'hF);
    rd(11'h7FC, 32'h0000_0000);
    $display("test read-only and unmapped done");
    d = $random(seed);
    wr(11'h230, d, 4'hF);
    wr(11'h230, ~d, 4'hF);
    rd(11'h230, d);
    wr(11'h540, 32'hFFFF_FFFF, 4'hF);
    wr(11'h540, 32'h0000_0000, 4'hF);
    rd(11'h540, 32'h00FF_0001);
    $display("test write-once done");
    STATUS_SET <= 16'h8100;
    @(posedge CLK);
    STATUS_SET <= 16'h0000;
    tick(1);
    rd(11'h018, 32'h0000_8110);
    wr(11'h018, 32'h0000_0000, 4'hF);
    rd(11'h018, 32'h0000_8110);
    wr(11'h018, 32'h0000_8000, 4'hF);
    rd(11'h018, 32'h0000_0110);
    $display("test write-one-clear done");
    LINK_UP <= 1'b1;
    tick(6);
    wr(11'h2C0, 32'h0000_0011, 4'hF);
    rd(11'h2C0, 32'h0000_0010);
    chk(32'(LINK_DISABLE), 32'h0000_0001, "disable level");
    wr(11'h010, 32'hFFFF_FFFF, 4'hF);
    rd(11'h010, 32'h0000_0000);
    wr(11'h2A0, 32'hFFFF_FFFF, 4'hF);
    rd(11'h2A0, 32'h0000_0000);
    wr(11'h3B0, 32'hFFFF_FFFF, 4'hF);
    rd(11'h3B0, 32'h0000_0000);
    LINK_UP <= 1'b0;
    tick(6);
    wr(11'h010, 32'hFFFF_FFFF, 4'hF);
    rd(11'h010, 32'h0000_0547);
    wr(11'h2A0, 32'hFFFF_FFFF, 4'hF);
    rd(11'h2A0, 32'h0000_000F);
    wr(11'h3B0, 32'hFFFF_FFFF, 4'hF);
    rd(11'h3B0, 32'h0000_0007);
    wr(11'h2C0, 32'h0000_0011, 4'hF);
    rd(11'h2C0, 32'h0000_0011);
    rd(11'h2C8, 32'h0000_1000);
    chk(32'(retrain_cnt), 32'h0000_0000, "no retrain yet");
    wr(11'h2C0, 32'h0000_0001, 4'hF);
    tick(3);
    chk(32'(retrain_cnt), 32'h0000_0001, "one retrain pulse");
    chk(32'(retrain_time - ack_time), 32'h0000_0014, "retrain delay ns");
    chk(32'(LINK_DISABLE), 32'h0000_0000, "disable released");
    rd(11'h2C8, 32'h0000_1800);
    LINK_UP <= 1'b1;
    tick(6);
    rd(11'h2C8, 32'h0000_3000);
    $display("test link reprogram done");
    RST_B <= 1'b0;
    tick(2);
    RST_B <= 1'b1;
    tick(3);
    rd(11'h090, 32'h0000_FFF1);
    rd(11'h0A0, 32'h0000_0000);
    rd(11'h3B0, 32'h0000_0000);
    d = $random(seed);
    wr(11'h230, d, 4'hF);
    rd(11'h230, d);
    $display("test second reset done");
    wrap_up();
  end
endmodule
